// *** sahi_dev.sv ***
`timescale 1ns/1ps
module sahi_dev
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  input wire logic output_format_select_i,
  input wire logic cmp_above_i,
  output logic [7:0] dac_code_o,
  sahi_if.dev bus
);
  typedef enum logic [3:0]
  {
    SAHI_IDLE = 4'h1,
    SAHI_SETUP = 4'h2,
    SAHI_BITS = 4'h4,
    SAHI_DONE = 4'h8
  } sahi_state_t;

  sahi_state_t state_ff;
  sahi_state_t nxt_state;
  logic [7:0] sar_ff;
  logic [7:0] trial_ff;
  logic [3:0] bit_ff;
  logic [7:0] result_ff;
  logic done_n_ff;
  logic wait_ff;
  logic [7:0] rd_ff;
  logic oe_n_ff;
  logic [7:0] dac_ff;
  logic sel_s1_ff;
  logic sel_s2_ff;

  wire start = bus.host_write_strobe | bus.dma_req;
  wire is_bits = state_ff == SAHI_BITS;
  wire [7:0] keep = cmp_above_i ? trial_ff : sahi_pkg::ZERO_W;
  wire [7:0] sar_kept = (sar_ff & ~trial_ff) | keep;
  wire last_bit = bit_ff == sahi_pkg::BIT_LAST;
  wire [7:0] fmt_data = sel_s2_ff ? result_ff : {~result_ff[7], result_ff[6:0]};

  // Wait is held from an accepted DMA start until the result is complete
  wire dma_start = bus.dma_req && nxt_state == SAHI_SETUP;
  wire nxt_wait = (wait_ff || dma_start) && !(nxt_state == SAHI_DONE);

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      SAHI_IDLE: if (start) nxt_state = SAHI_SETUP;
      SAHI_SETUP: nxt_state = SAHI_BITS;
      SAHI_BITS: if (last_bit) nxt_state = SAHI_DONE;
      SAHI_DONE: if (start) nxt_state = SAHI_SETUP;
      default: nxt_state = SAHI_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_ff <= SAHI_IDLE;
      sar_ff <= sahi_pkg::ZERO_W;
      trial_ff <= sahi_pkg::ZERO_W;
      bit_ff <= sahi_pkg::BIT_FIRST;
      result_ff <= sahi_pkg::ZERO_W;
      dac_ff <= sahi_pkg::ZERO_W;
    end
    else if (clk_en_i)
    begin
      state_ff <= nxt_state;
      if (nxt_state == SAHI_SETUP)
      begin
        // Setup cycle plus eight bit cycles gives nine
        sar_ff <= sahi_pkg::MSB_MASK;
        trial_ff <= sahi_pkg::MSB_MASK;
        bit_ff <= sahi_pkg::BIT_FIRST;
        dac_ff <= sahi_pkg::MSB_MASK;
      end
      else if (is_bits)
      begin
        sar_ff <= sar_kept | (trial_ff >> 1);
        dac_ff <= sar_kept | (trial_ff >> 1);
        trial_ff <= trial_ff >> 1;
        bit_ff <= bit_ff - 4'h1;
        if (last_bit)
          result_ff <= sar_kept;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      done_n_ff <= 1'b1;
      wait_ff <= 1'b0;
      rd_ff <= sahi_pkg::ZERO_W;
      oe_n_ff <= 1'b1;
      sel_s1_ff <= 1'b1;
      sel_s2_ff <= 1'b1;
    end
    else if (clk_en_i)
    begin
      sel_s1_ff <= output_format_select_i;
      sel_s2_ff <= sel_s1_ff;
      done_n_ff <= !(nxt_state == SAHI_DONE);
      wait_ff <= nxt_wait;
      oe_n_ff <= !(bus.host_read_strobe && state_ff == SAHI_DONE);
      rd_ff <= fmt_data;
    end
  end

  assign bus.conversion_done_n = done_n_ff;
  assign bus.dma_wait = wait_ff;
  assign bus.rd_data = rd_ff;
  assign bus.rd_data_oe_n = oe_n_ff;
  assign dac_code_o = dac_ff;
endmodule

// *** sahi_pkg.sv ***
package sahi_pkg;
  localparam int DATA_W = 8;
  localparam int MIN_CONV_CYC = 9;
  // Reference rate and budget for one conversion
  localparam int REF_CLK_MHZ = 10;
  localparam int CONV_TIME_NS = 1000;
  localparam int CONV_BUDGET_CYC = (CONV_TIME_NS * REF_CLK_MHZ) / 1000;
  localparam logic [DATA_W-1:0] MSB_MASK = 8'h80;
  localparam logic [DATA_W-1:0] ZERO_W = 8'h00;
  localparam logic [3:0] BIT_LAST = 4'h0;
  localparam logic [3:0] BIT_FIRST = 4'h7;
  localparam logic [15:0] ONE_16 = 16'h0001;
endpackage

// *** sahi_if.sv ***
`timescale 1ns/1ps
interface sahi_if;
  logic host_write_strobe;
  logic host_read_strobe;
  logic conversion_done_n;
  logic [7:0] rd_data;
  logic rd_data_oe_n;
  logic dma_req;
  logic dma_wait;
  modport dev
  (
    input host_write_strobe, host_read_strobe, dma_req,
    output conversion_done_n, rd_data, rd_data_oe_n, dma_wait
  );
  modport host
  (
    output host_write_strobe, host_read_strobe, dma_req,
    input conversion_done_n, rd_data, rd_data_oe_n, dma_wait
  );
endinterface

// *** sahi_host.sv ***
`timescale 1ns/1ps
module sahi_host
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  input wire logic conv_req_i,
  input wire logic dma_mode_i,
  input wire logic [15:0] block_len_i,
  output logic conv_busy_o,
  output logic res_valid_o,
  input wire logic res_ready_i,
  output logic [7:0] res_data_o,
  sahi_if.host bus
);
  typedef enum logic [3:0]
  {
    SAHH_IDLE = 4'h1,
    SAHH_START = 4'h2,
    SAHH_WAIT = 4'h4,
    SAHH_READ = 4'h8
  } sahh_state_t;

  sahh_state_t state_ff;
  sahh_state_t nxt_state;
  logic [15:0] left_ff;
  logic dma_ff;
  logic wr_ff;
  logic rd_ff;
  logic [7:0] buf0_ff;
  logic [7:0] buf1_ff;
  logic [1:0] cnt_ff;
  logic busy_ff;

  wire done = !bus.conversion_done_n;
  wire space = cnt_ff != 2'h2;
  wire take = state_ff == SAHH_READ && !bus.rd_data_oe_n && space;
  wire pop = res_ready_i && cnt_ff != 2'h0;
  wire more = dma_ff && left_ff != sahi_pkg::ONE_16;
  // Mode of the next start: taken from the input when a block begins
  wire next_dma = (state_ff == SAHH_IDLE) ? dma_mode_i : dma_ff;

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      SAHH_IDLE: if (conv_req_i && space) nxt_state = SAHH_START;
      SAHH_START: nxt_state = SAHH_WAIT;
      SAHH_WAIT: if (done && !bus.dma_wait) nxt_state = SAHH_READ;
      SAHH_READ: if (take) nxt_state = more ? SAHH_START : SAHH_IDLE;
      default: nxt_state = SAHH_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_ff <= SAHH_IDLE;
      left_ff <= 16'h0000;
      dma_ff <= 1'b0;
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      busy_ff <= 1'b0;
    end
    else if (clk_en_i)
    begin
      state_ff <= nxt_state;
      busy_ff <= nxt_state != SAHH_IDLE;
      wr_ff <= nxt_state == SAHH_START && !next_dma;
      rd_ff <= nxt_state == SAHH_READ;
      if (state_ff == SAHH_IDLE && nxt_state == SAHH_START)
      begin
        dma_ff <= dma_mode_i;
        left_ff <= block_len_i;
      end
      else if (take)
        left_ff <= left_ff - sahi_pkg::ONE_16;
    end
  end

  // Request is a one-cycle pulse with the start; DMA wait gates the read
  logic dreq_ff;
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      dreq_ff <= 1'b0;
    else if (clk_en_i)
      dreq_ff <= next_dma && nxt_state == SAHH_START;
  end

  // Two-entry result buffer
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      buf0_ff <= sahi_pkg::ZERO_W;
      buf1_ff <= sahi_pkg::ZERO_W;
      cnt_ff <= 2'h0;
    end
    else if (clk_en_i)
    begin
      if (pop)
        buf0_ff <= (cnt_ff == 2'h2) ? buf1_ff : bus.rd_data;
      if (take && (cnt_ff == 2'h0 || (cnt_ff == 2'h1 && pop)))
        buf0_ff <= bus.rd_data;
      else if (take)
        buf1_ff <= bus.rd_data;
      cnt_ff <= cnt_ff + {1'b0, take} - {1'b0, pop};
    end
  end

  assign bus.host_write_strobe = wr_ff;
  assign bus.host_read_strobe = rd_ff;
  assign bus.dma_req = dreq_ff;
  assign conv_busy_o = busy_ff;
  assign res_valid_o = cnt_ff != 2'h0;
  assign res_data_o = buf0_ff;
endmodule

// *** sahi_checker.sv ***
`timescale 1ns/1ps
module sahi_checker
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic host_write_strobe,
  input wire logic host_read_strobe,
  input wire logic conversion_done_n,
  input wire logic [7:0] rd_data,
  input wire logic rd_data_oe_n,
  input wire logic dma_req,
  input wire logic dma_wait
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  a_write_done_time: assert property (host_write_strobe |=> conversion_done_n [*8] ##2 !conversion_done_n)
    else $error("write start: done not after ten cycles");
  a_dma_done_time: assert property (dma_req |=> conversion_done_n [*8] ##2 !conversion_done_n)
    else $error("dma start: done not after ten cycles");
  a_done_cause: assert property ($fell(conversion_done_n) |-> $past(host_write_strobe || dma_req, 10))
    else $error("done without start ten cycles before");
  a_read_waits: assert property ($rose(host_read_strobe) |-> !conversion_done_n)
    else $error("read before done");
  a_drive_after_done: assert property (!rd_data_oe_n |-> !conversion_done_n)
    else $error("data driven while converting");
  a_data_steady: assert property (!rd_data_oe_n && $past(!rd_data_oe_n) |-> $stable(rd_data))
    else $error("read data changed while driven");
  a_wait_in_conv: assert property (dma_wait |-> conversion_done_n || $past(conversion_done_n))
    else $error("dma held after done");
  a_strobe_pulse: assert property (host_write_strobe |=> !host_write_strobe)
    else $error("write strobe longer than one cycle");
  cover property (host_write_strobe);
  cover property (dma_req ##1 dma_wait);
  cover property (!rd_data_oe_n);
endmodule

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
  logic sys_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic fmt = 1'b1;
  logic req = 1'b0;
  logic dma = 1'b0;
  logic rdy = 1'b0;
  logic busy;
  logic vld;
  logic [7:0] vin = 8'h00;
  logic [7:0] dac;
  logic [7:0] res;
  int n_fail = 0;
  int n_checks = 0;
  // Format bit, analog level, expected code
  logic [16:0] rows [5] = '{17'h10000, 17'h1ffff, 17'h05ada, 17'h08000, 17'h10101};
  sahi_if bus();
  always #25 sys_clk_i = ~sys_clk_i;
  sahi_dev i_sahi_dev (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .clk_en_i(1'b1),
    .output_format_select_i(fmt), .cmp_above_i(vin >= dac), .dac_code_o(dac), .bus(bus.dev));
  sahi_host i_sahi_host (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .clk_en_i(1'b1), .conv_req_i(req),
    .dma_mode_i(dma), .block_len_i(16'h0003), .conv_busy_o(busy), .res_valid_o(vld),
    .res_ready_i(rdy), .res_data_o(res), .bus(bus.host));
  sahi_checker i_sahi_checker (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
    .host_write_strobe(bus.host_write_strobe), .host_read_strobe(bus.host_read_strobe),
    .conversion_done_n(bus.conversion_done_n), .rd_data(bus.rd_data),
    .rd_data_oe_n(bus.rd_data_oe_n), .dma_req(bus.dma_req), .dma_wait(bus.dma_wait));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Waits for a buffered result, checks it and pops it
  task automatic take(input logic [7:0] exp);
    int i;
    for (i = 0; i < 100 && vld !== 1'b1; i++)
      @(negedge sys_clk_i);
    if (i == 100)
    begin
      n_fail++;
      give_verdict();
    end
    chk(res, exp);
    rdy = 1'b1;
    @(negedge sys_clk_i);
    rdy = 1'b0;
  endtask
  initial
  begin
    repeat (10) @(negedge sys_clk_i);
    chk({7'h00, bus.conversion_done_n}, 8'h01);
    chk({7'h00, bus.rd_data_oe_n}, 8'h01);
    arst_n_i = 1'b1;
    foreach (rows[k])
    begin
      fmt = rows[k][16];
      vin = rows[k][15:8];
      repeat (3) @(negedge sys_clk_i);
      req = 1'b1;
      @(negedge sys_clk_i);
      req = 1'b0;
      take(rows[k][7:0]);
      $display("single conversion %0d done", k);
    end
    // Block of three with the reader stalled until the buffer is full
    vin = 8'h3c;
    dma = 1'b1;
    req = 1'b1;
    @(negedge sys_clk_i);
    req = 1'b0;
    repeat (60) @(negedge sys_clk_i);
    chk({7'h00, vld}, 8'h01);
    repeat (3) take(8'h3c);
    repeat (30) @(negedge sys_clk_i);
    chk({6'h00, busy, vld}, 8'h00);
    $display("dma block done");
    // Reset in mid conversion, then one clean conversion
    dma = 1'b0;
    vin = 8'h77;
    req = 1'b1;
    @(negedge sys_clk_i);
    req = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    arst_n_i = 1'b0;
    @(negedge sys_clk_i);
    chk({6'h00, bus.conversion_done_n, bus.rd_data_oe_n}, 8'h03);
    chk({6'h00, busy, vld}, 8'h00);
    arst_n_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    req = 1'b1;
    @(negedge sys_clk_i);
    req = 1'b0;
    take(8'h77);
    $display("mid-run reset done");
    give_verdict();
  end
endmodule
